// [bench/asc_core_model.sv]
// analog side model: input mux plus sampling core answering the control block
// assumes the bench picks the input level class through inMode
`timescale 1ns/100ps
module asc_core_model (
  input  logic       core_clk,   // system clock
  input  logic [3:0] chanSel,    // selected analog input
  input  logic       coreEnable, // core powered
  input  logic [1:0] inMode,     // 0 in range, 1 above, 2 below reference
  output logic [9:0] coreCode,   // result code
  output logic       coreOver,   // above upper reference
  output logic       coreUnder   // below lower reference
);
  initial begin
    coreCode = 10'h000;
    coreOver = 1'b0;
    coreUnder = 1'b0;
  end
  // powered core reports a code that names its input; unpowered outputs wander
  always @(posedge core_clk) begin
    if (coreEnable) begin
      coreCode <= {chanSel, 6'h2A};
      coreOver <= inMode == 2'h1;
      coreUnder <= inMode == 2'h2;
    end else begin
      coreCode <= ~coreCode;
      coreOver <= ~coreOver;
      coreUnder <= ~coreUnder;
    end
  end
endmodule

// [bench/asc_sar_control_asserts.sv]
// port checker for the sar converter control block
// assumes one clock domain and binding onto asc_sar_control
`timescale 1ns/100ps
`include "asc_defines.vh"
module asc_sar_control_asserts (
  input logic        core_clk, rst_b,                     // clock, reset
  input logic        hsel, hwrite, hready,                // bus controls
  input logic [1:0]  htrans,                              // transfer type
  input logic [31:0] haddr, hwdata, hrdata,               // bus address and data
  input logic        haltMode,                            // halt request
  input logic [3:0]  chanSel,                             // input select
  input logic        coreEnable, coreSample, coreTake,    // core controls
  input logic        convClkEn, doneIrq, wakeReq          // tick, irq, wake
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic       wrCsr_reg;  // control write in data phase
  logic       rdLow_reg;  // low result read in data phase
  logic [3:0] chanExp_reg; // channel written
  // follow address phases into their data phases
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrCsr_reg <= 1'b0;
      rdLow_reg <= 1'b0;
      chanExp_reg <= 4'h0;
    end else begin
      wrCsr_reg <= hsel && hready && htrans[1] && hwrite && haddr[9:0] == `ASC_ADDR_CSR;
      rdLow_reg <= hsel && hready && htrans[1] && !hwrite && haddr[9:0] == `ASC_ADDR_RESL;
      chanExp_reg <= hwdata[3:0];
    end
  end
  chan_write_a: assert property (wrCsr_reg |=> chanSel == chanExp_reg) else $error("channel not taken");
  low_zero_a: assert property (rdLow_reg |-> hrdata[31:2] == 30'h0) else $error("low result upper bits set");
  take_on_a: assert property (coreTake |-> coreEnable) else $error("sample taken while off");
  halt_off_a: assert property (haltMode [*5] |-> !coreEnable) else $error("core on in halt");
  halt_wake_a: assert property (haltMode [*5] |-> !wakeReq) else $error("wake from halt");
  wake_irq_a: assert property (wakeReq |-> doneIrq) else $error("wake without irq");
  tick_gap_a: assert property (convClkEn |=> !convClkEn [*8]) else $error("ticks too close");
  chan_restart_a: assert property ($changed(chanSel) && coreEnable |-> ##[0:1] coreSample)
    else $error("no restart on channel change");
  cover property (coreTake);
  cover property (wakeReq);
  cover property ($changed(chanSel) && coreEnable);
endmodule
bind asc_sar_control asc_sar_control_asserts chk_u (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .htrans(htrans), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
  .haltMode(haltMode), .chanSel(chanSel), .coreEnable(coreEnable), .coreSample(coreSample),
  .coreTake(coreTake), .convClkEn(convClkEn), .doneIrq(doneIrq), .wakeReq(wakeReq));

// [bench/tb_asc_sar_control.sv]
// self-checking bench for the sar converter control block
// assumes the analog model in asc_core_model and a one-cycle bus answer
`timescale 1ns/100ps
`include "asc_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_asc_sar_control;
  logic        core_clk, rst_b, hsel, hwrite, hreadyout, hresp, waitMode, haltMode, coreOver, coreUnder;
  logic [1:0]  htrans, inMode;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [9:0]  coreCode;
  logic [3:0]  chanSel;
  logic        coreEnable, coreSample, coreTake, convClkEn, doneIrq, wakeReq;
  int          error_cnt, checks_done;
  asc_sar_control dut_u (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .waitMode(waitMode), .haltMode(haltMode), .coreCode(coreCode), .coreOver(coreOver),
    .coreUnder(coreUnder), .chanSel(chanSel), .coreEnable(coreEnable), .coreSample(coreSample),
    .coreTake(coreTake), .convClkEn(convClkEn), .doneIrq(doneIrq), .wakeReq(wakeReq));
  asc_core_model core_u (.core_clk(core_clk), .chanSel(chanSel), .coreEnable(coreEnable), .inMode(inMode),
    .coreCode(coreCode), .coreOver(coreOver), .coreUnder(coreUnder));
  // clock at 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // one single transfer: address phase, then data phase; read data lands in rdv
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rdv = hrdata;
  endtask
  task wr(input logic [9:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task rd(input logic [9:0] a); bus(1'b0, a, 32'h0); endtask
  // poll the control register until a conversion has ended
  task waitDone;
    int n;
    n = 0;
    rd(`ASC_ADDR_CSR);
    while (rdv[7] !== 1'b1 && n < 3000) begin rd(`ASC_ADDR_CSR); n++; end
    `CHK(rdv[7], 1'b1)
  endtask
  // reset values, unmapped place reads zero
  task tRegs;
    logic [9:0] al [5];
    al = '{`ASC_ADDR_CSR, `ASC_ADDR_RESH, `ASC_ADDR_RESL, `ASC_ADDR_AUX, 10'h200};
    for (int i = 0; i < 5; i++) begin rd(al[i]); `CHK(rdv, 32'h0) end
  endtask
  // first conversion, result split and flag clear by high read
  task tConv;
    wr(`ASC_ADDR_AUX, 32'h1);
    wr(`ASC_ADDR_CSR, 32'h15);
    waitDone;
    `CHK(doneIrq, 1'b1)
    rd(`ASC_ADDR_RESL); `CHK(rdv, 32'h2)
    rd(`ASC_ADDR_RESH); `CHK(rdv, 32'h5A)
    wr(`ASC_ADDR_CSR, 32'h95);
    rd(`ASC_ADDR_CSR); `CHK(rdv, 32'h15)
  endtask
  // lock across conversions, then saturation both ways
  task tLock;
    waitDone;
    rd(`ASC_ADDR_RESL);
    inMode <= 2'h1;
    repeat (800) @(posedge core_clk);
    rd(`ASC_ADDR_RESH); `CHK(rdv, 32'h5A)
    waitDone;
    rd(`ASC_ADDR_RESL); `CHK(rdv, 32'h3)
    rd(`ASC_ADDR_RESH); `CHK(rdv, 32'hFF)
    inMode <= 2'h2;
    waitDone;
    rd(`ASC_ADDR_RESL); `CHK(rdv, 32'h0)
    rd(`ASC_ADDR_RESH); `CHK(rdv, 32'h0)
    inMode <= 2'h0;
  endtask
  // every channel code, each written while converting
  task tChan;
    for (int c = 0; c < 16; c++) begin
      wr(`ASC_ADDR_CSR, 32'h10 | c);
      rd(`ASC_ADDR_RESH);
      rd(`ASC_ADDR_CSR); `CHK(rdv[7], 1'b0)
      waitDone;
      rd(`ASC_ADDR_RESH); `CHK(rdv, {24'h0, c[3:0], 4'hA})
    end
  endtask
  // converter tick period for divider codes 0 to 2
  task tDiv;
    int n;
    for (int d = 0; d < 3; d++) begin
      wr(`ASC_ADDR_CSR, 32'h10 | (d << 5));
      repeat (2) begin
        n = 1;
        @(posedge core_clk);
        while (convClkEn !== 1'b1 && n < 300) begin @(posedge core_clk); n++; end
      end
      `CHK(n, 25 << d)
    end
  endtask
  // long sampling phase lasts six ticks
  task tLong;
    int n;
    wr(`ASC_ADDR_CSR, 32'h10);
    wr(`ASC_ADDR_AUX, 32'h3);
    repeat (400) @(posedge core_clk);
    n = 0;
    while (coreSample !== 1'b0 && n < 999) begin @(posedge core_clk); n++; end
    while (coreSample !== 1'b1 && n < 999) begin @(posedge core_clk); n++; end
    n = 0;
    while (coreSample === 1'b1 && n < 999) begin @(posedge core_clk); n++; end
    `CHK(n > 125 && n < 176, 1'b1)
    wr(`ASC_ADDR_AUX, 32'h1);
  endtask
  // wait mode keeps converting and wakes; halt stops and does not wake
  task tModes;
    waitMode <= 1'b1;
    rd(`ASC_ADDR_RESH);
    waitDone;
    `CHK(wakeReq, 1'b1)
    haltMode <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(coreEnable, 1'b0)
    `CHK(wakeReq, 1'b0)
    haltMode <= 1'b0;
    waitMode <= 1'b0;
  endtask
  // switching off aborts, clears the flag and the lock
  task tOff;
    rd(`ASC_ADDR_RESL);
    wr(`ASC_ADDR_CSR, 32'h0);
    repeat (2) @(posedge core_clk);
    `CHK(coreEnable, 1'b0)
    rd(`ASC_ADDR_CSR); `CHK(rdv, 32'h0)
    repeat (400) @(posedge core_clk);
    `CHK(doneIrq, 1'b0)
    inMode <= 2'h1;
    wr(`ASC_ADDR_CSR, 32'h10);
    waitDone;
    rd(`ASC_ADDR_RESH); `CHK(rdv, 32'hFF)
  endtask
  task complete_run;
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    rst_b = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    waitMode = 1'b0; haltMode = 1'b0; inMode = 2'h0; error_cnt = 0; checks_done = 0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    tRegs; tConv; tLock; tChan; tDiv; tLong; tModes; tOff;
    complete_run;
  end
  // watchdog against a hang
  initial begin
    #400000;
    error_cnt++;
    complete_run;
  end
endmodule

// [design/asc_defines.vh]
// constants for the sar converter control block: offsets, fields, reset values, timing
// assumes inclusion by bare name from design files
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// register byte addresses (printed offsets are indices, byte address = 4 * index)
`define ASC_IDX_CSR        8'h2E
`define ASC_IDX_RESH       8'h2F
`define ASC_IDX_RESL       8'h30
`define ASC_IDX_AUX        8'h31
`define ASC_ADDR_CSR       10'h0B8
`define ASC_ADDR_RESH      10'h0BC
`define ASC_ADDR_RESL      10'h0C0
`define ASC_ADDR_AUX       10'h0C4

// control/status fields
`define ASC_CSR_DONE       7
`define ASC_CSR_DIV_HI     6
`define ASC_CSR_DIV_LO     5
`define ASC_CSR_ON         4
`define ASC_CSR_CH_HI      3
`define ASC_CSR_CH_LO      0

// auxiliary register fields (irq enable, long sample)
`define ASC_AUX_IRQEN      0
`define ASC_AUX_LONG       1

// reset values
`define ASC_CSR_RST        8'h00
`define ASC_RES_RST        10'h000
`define ASC_AUX_RST        2'h0

// saturation codes
`define ASC_RES_FULL       10'h3FF
`define ASC_RES_ZERO       10'h000

// timing: system clock and converter clock rates in khz
`define ASC_SYS_KHZ        100000
`define ASC_F4_KHZ         4000
`define ASC_F2_KHZ         2000
`define ASC_F1_KHZ         1000
`define ASC_DIV4           (`ASC_SYS_KHZ / `ASC_F4_KHZ)
`define ASC_DIV2           (`ASC_SYS_KHZ / `ASC_F2_KHZ)
`define ASC_DIV1           (`ASC_SYS_KHZ / `ASC_F1_KHZ)

// sequencer lengths in converter clock cycles
`define ASC_SAMPLE_SHORT   4'h3
`define ASC_SAMPLE_LONG    4'h6
`define ASC_BITS_CYCLES    4'hA

`endif

// [design/asc_sar_control.v]
// sar converter control: ahb-lite register slave, prescaler, sequencer, result lock
// assumes an analog core that samples/holds on request and reports a 10-bit code
// plus over/under range flags when its conversion ends
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "asc_defines.vh"

module asc_sar_control #(
  parameter CH_COUNT = 16                   // number of analog inputs
) (
  input  wire        core_clk,              // system clock, 100 MHz
  input  wire        rst_b,                 // async reset, active low
  input  wire        hsel,                  // ahb slave select
  input  wire [31:0] haddr,                 // ahb address
  input  wire [1:0]  htrans,                // ahb transfer type
  input  wire        hwrite,                // ahb write
  input  wire [2:0]  hsize,                 // ahb size
  input  wire [31:0] hwdata,                // ahb write data
  input  wire        hready,                // ahb bus ready
  output reg  [31:0] hrdata,                // ahb read data
  output wire        hreadyout,             // ahb slave ready
  output wire        hresp,                 // ahb response, always okay
  input  wire        waitMode,              // processor in wait mode
  input  wire        haltMode,              // processor in halt mode
  input  wire [9:0]  coreCode,              // converter core result code
  input  wire        coreOver,              // input above upper reference
  input  wire        coreUnder,             // input below lower reference
  output reg  [3:0]  chanSel,               // analog input mux select
  output reg         coreEnable,            // converter core powered
  output reg         coreSample,            // sample switch closed
  output reg         coreTake,              // pulse: core code is sampled now
  output reg         convClkEn,             // pulse: one converter clock tick
  output wire        doneIrq,               // end-of-conversion interrupt request
  output wire        wakeReq                // wake request toward power control
);

  // sequencer states, one-hot
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_SAMPLE = 3'b010;
  localparam [2:0] ST_CONV   = 3'b100;

  // prescaler tops, worked out at full width then cut to the counter width
  localparam [31:0] DIV4_FULL = `ASC_DIV4;
  localparam [31:0] DIV2_FULL = `ASC_DIV2;
  localparam [31:0] DIV1_FULL = `ASC_DIV1;
  localparam [6:0]  DIV4      = DIV4_FULL[6:0];
  localparam [6:0]  DIV2      = DIV2_FULL[6:0];
  localparam [6:0]  DIV1      = DIV1_FULL[6:0];

  // input synchronisers for the core status pins (from analog domain) and the wait/halt mode levels
  reg  [11:0] coreMeta_reg;
  reg  [11:0] coreSync_reg;
  reg         modeMeta_reg;
  reg         modeSync_reg;
  reg         haltMeta_reg;
  reg         haltSync_reg;

  // registers
  reg  [1:0]  divSel_reg;
  reg         convOn_reg;
  reg         done_reg;
  reg  [9:0]  result_reg;
  reg         lock_reg;
  reg  [1:0]  aux_reg;
  reg  [2:0]  state_reg;
  reg  [6:0]  preCnt_reg;
  reg  [3:0]  phaseCnt_reg;

  // ahb address phase capture
  reg         wrPend_reg;
  reg         rdPend_reg;
  reg  [9:0]  addrPend_reg;

  wire        accept;
  wire        wrCsr;
  wire        wrAux;
  wire        rdHigh;
  wire        rdLow;
  wire        runEn;
  wire        chanChange;
  wire        convEnd;
  wire [6:0]  divTop;
  wire [3:0]  sampleLen;
  wire [9:0]  takenCode;
  wire [7:0]  csrView;
  wire        resultLoad;
  reg  [31:0] rdMux;

  // two flops on the core result and range pins (from the analog domain)
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      coreMeta_reg <= 12'h000;
      coreSync_reg <= 12'h000;
    end else begin
      coreMeta_reg <= {coreOver, coreUnder, coreCode};
      coreSync_reg <= coreMeta_reg;
    end
  end

  // two flops on the low-power mode levels from the power controller
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeMeta_reg <= 1'b0;
      modeSync_reg <= 1'b0;
      haltMeta_reg <= 1'b0;
      haltSync_reg <= 1'b0;
    end else begin
      modeMeta_reg <= waitMode;
      modeSync_reg <= modeMeta_reg;
      haltMeta_reg <= haltMode;
      haltSync_reg <= haltMeta_reg;
    end
  end

  // ahb-lite: zero wait states, okay only
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign accept    = hsel & hready & htrans[1];

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_reg   <= 1'b0;
      rdPend_reg   <= 1'b0;
      addrPend_reg <= 10'h000;
    end else begin
      wrPend_reg   <= accept & hwrite;
      rdPend_reg   <= accept & ~hwrite;
      addrPend_reg <= haddr[9:0];
    end
  end

  assign wrCsr  = wrPend_reg & (addrPend_reg == `ASC_ADDR_CSR);
  assign wrAux  = wrPend_reg & (addrPend_reg == `ASC_ADDR_AUX);
  // reads take effect in the address phase, data returned next cycle
  assign rdHigh = accept & ~hwrite & (haddr[9:0] == `ASC_ADDR_RESH);
  assign rdLow  = accept & ~hwrite & (haddr[9:0] == `ASC_ADDR_RESL);

  // control view: done flag shown only while the converter is on
  assign csrView = {done_reg & convOn_reg, divSel_reg, convOn_reg, chanSel};

  // read multiplexer over the register map
  always @* begin
    case (haddr[9:0])
      `ASC_ADDR_CSR:  rdMux = {24'h000000, csrView};
      `ASC_ADDR_RESH: rdMux = {24'h000000, result_reg[9:2]};
      `ASC_ADDR_RESL: rdMux = {30'h0000000, result_reg[1:0]};
      `ASC_ADDR_AUX:  rdMux = {30'h0000000, aux_reg};
      default:        rdMux = 32'h00000000;
    endcase
  end

  // read data, registered in the address phase and held until the next read
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (accept & ~hwrite) begin
      hrdata <= rdMux;
    end
  end

  // control register writes; done flag is read-only and ignores data
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chanSel    <= 4'h0;
      divSel_reg <= 2'h0;
      convOn_reg <= 1'b0;
    end else if (wrCsr) begin
      chanSel    <= hwdata[`ASC_CSR_CH_HI:`ASC_CSR_CH_LO];
      divSel_reg <= hwdata[`ASC_CSR_DIV_HI:`ASC_CSR_DIV_LO];
      convOn_reg <= hwdata[`ASC_CSR_ON];
    end
  end

  // auxiliary register: interrupt enable and long sampling select
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_reg <= `ASC_AUX_RST;
    end else if (wrAux) begin
      aux_reg <= hwdata[1:0];
    end
  end

  // a write of a new channel restarts the sample at once
  assign chanChange = wrCsr & (hwdata[3:0] != chanSel);
  // halt stops the converter, wait leaves it alone
  assign runEn      = convOn_reg & ~haltSync_reg;

  // prescaler: one-cycle tick at the selected converter rate
  assign divTop = (divSel_reg == 2'b00) ? DIV4 :
                  (divSel_reg == 2'b01) ? DIV2 : DIV1;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      preCnt_reg <= 7'h00;
      convClkEn  <= 1'b0;
    end else if (!runEn || preCnt_reg >= divTop - 7'h01) begin
      preCnt_reg <= 7'h00;
      convClkEn  <= runEn;
    end else begin
      preCnt_reg <= preCnt_reg + 7'h01;
      convClkEn  <= 1'b0;
    end
  end

  // sampling length in ticks; conversion ends only while still enabled
  assign sampleLen = aux_reg[`ASC_AUX_LONG] ? `ASC_SAMPLE_LONG : `ASC_SAMPLE_SHORT;
  assign convEnd   = convClkEn & runEn & (state_reg == ST_CONV) &
                     (phaseCnt_reg == `ASC_BITS_CYCLES - 4'h1);

  // core power follows the run enable; take pulses one cycle after the end
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      coreTake   <= 1'b0;
      coreEnable <= 1'b0;
    end else begin
      coreTake   <= convEnd;
      coreEnable <= runEn;
    end
  end

  // conversion sequencer: sample, convert, take, restart
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_IDLE;
      phaseCnt_reg <= 4'h0;
      coreSample   <= 1'b0;
    end else begin
      if (!runEn) begin
        state_reg    <= ST_IDLE;
        phaseCnt_reg <= 4'h0;
        coreSample   <= 1'b0;
      end else if (chanChange) begin
        state_reg    <= ST_SAMPLE;
        phaseCnt_reg <= 4'h0;
        coreSample   <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            state_reg    <= ST_SAMPLE;
            phaseCnt_reg <= 4'h0;
            coreSample   <= 1'b1;
          end
          ST_SAMPLE: begin
            if (convClkEn) begin
              if (phaseCnt_reg == sampleLen - 4'h1) begin
                state_reg    <= ST_CONV;
                phaseCnt_reg <= 4'h0;
                coreSample   <= 1'b0;
              end else begin
                phaseCnt_reg <= phaseCnt_reg + 4'h1;
              end
            end
          end
          ST_CONV: begin
            if (convClkEn) begin
              if (convEnd) begin
                state_reg    <= ST_SAMPLE;
                phaseCnt_reg <= 4'h0;
                coreSample   <= 1'b1;
              end else begin
                phaseCnt_reg <= phaseCnt_reg + 4'h1;
              end
            end
          end
          default: begin
            state_reg    <= ST_IDLE;
            phaseCnt_reg <= 4'h0;
            coreSample   <= 1'b0;
          end
        endcase
      end
    end
  end

  // saturate out-of-range samples
  assign takenCode = coreSync_reg[11] ? `ASC_RES_FULL :
                     coreSync_reg[10] ? `ASC_RES_ZERO :
                     coreSync_reg[9:0];

  // result lock: a low read locks, a high read or switching off releases
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_reg <= 1'b0;
    end else if (!convOn_reg || rdHigh) begin
      lock_reg <= 1'b0;
    end else if (rdLow) begin
      lock_reg <= 1'b1;
    end
  end

  // load at conversion end unless locked; a low read in the same cycle keeps the old
  // sample, a high read in the same cycle has already taken the old high byte
  assign resultLoad = convEnd & (~lock_reg | rdHigh) & ~rdLow;

  // converted result, replaced only when the next conversion ends
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_reg <= `ASC_RES_RST;
    end else if (resultLoad) begin
      result_reg <= takenCode;
    end
  end

  // done flag: set only at a conversion end, so it stays low while the first one runs
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
    end else if (!convOn_reg) begin
      done_reg <= 1'b0;
    end else if (convEnd) begin
      done_reg <= 1'b1;
    end else if (rdHigh) begin
      done_reg <= 1'b0;
    end
  end

  // irq from the done flag while the converter is on and the irq is enabled
  assign doneIrq = done_reg & convOn_reg & aux_reg[`ASC_AUX_IRQEN];

  // wake toward power control only from wait, never from halt
  assign wakeReq = doneIrq & modeSync_reg & ~haltSync_reg;

endmodule
